// [logic/tta_base_counter.v]
// base counter with prescaler, double-buffered period/compare and register port
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "tta_defs.vh"

module tta_base_counter #(
  parameter NUM_CH = 3,
  parameter PRESC_W = 10
) (
  // clock and reset
  input wire CLOCK,
  input wire RESET,
  // register port
  input wire [4:0] ADDR,
  input wire [15:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [15:0] RDATA,
  // event system
  input wire EVENT_IN,
  output reg OVF_EVENT,
  output reg HIGH_OVF_EVENT,
  output reg [NUM_CH-1:0] CMP_EVENT,
  output reg [NUM_CH-1:0] HIGH_CMP_EVENT
);

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  reg enable_ff;
  reg [2:0] prescale_select_ff;
  reg split_ff;
  reg upd_bottom_ff;
  reg dir_down_ff;
  reg update_lock_ff;
  reg count_on_event_enable_ff;
  reg [1:0] ev_action_ff;
  reg [15:0] count_value_ff;
  reg [15:0] period_ff;
  reg [15:0] period_shadow_ff;
  reg period_shadow_valid_ff;
  reg [7:0] flags_ff;
  reg [PRESC_W-1:0] presc_ff;
  reg ev_prev_ff;

  wire [NUM_CH*16-1:0] cmp_all;
  wire [NUM_CH*16-1:0] cshd_all;
  wire [NUM_CH-1:0] compare_shadow_valid;
  wire [NUM_CH-1:0] match16;
  wire [NUM_CH-1:0] match_lo;
  wire [NUM_CH-1:0] match_hi;

  wire wr_main = WR && (ADDR == `TTA_ADDR_MAIN_CTRL);
  wire wr_mode = WR && (ADDR == `TTA_ADDR_MODE);
  wire wr_cmd = WR && (ADDR == `TTA_ADDR_CMD_CTRL);
  wire wr_evc = WR && (ADDR == `TTA_ADDR_EVENT_CTRL);
  wire wr_flags = WR && (ADDR == `TTA_ADDR_FLAGS);
  wire wr_count = WR && (ADDR == `TTA_ADDR_COUNT);
  wire wr_period = WR && (ADDR == `TTA_ADDR_PERIOD);
  wire wr_pshd = WR && (ADDR == `TTA_ADDR_PERIOD_SHD);

  // ---------------------------------------------------------------
  // tick generation
  // ---------------------------------------------------------------
  reg [PRESC_W-1:0] presc_mask;
  always @* begin
    case (prescale_select_ff)
      3'h0: presc_mask = 10'h000;
      3'h1: presc_mask = 10'h001;
      3'h2: presc_mask = 10'h003;
      3'h3: presc_mask = 10'h007;
      3'h4: presc_mask = 10'h00f;
      3'h5: presc_mask = 10'h03f;
      3'h6: presc_mask = 10'h0ff;
      default: presc_mask = 10'h3ff;
    endcase
  end

  // event system runs on this clock, so no synchroniser is needed
  wire ev_rise = EVENT_IN && !ev_prev_ff;
  wire presc_tick = ((presc_ff & presc_mask) == presc_mask);
  wire tick = enable_ff && (count_on_event_enable_ff ? ev_rise : presc_tick);
  wire restart = enable_ff && ev_rise && (ev_action_ff == `TTA_EVACT_RESTART);
  wire down = (ev_action_ff == `TTA_EVACT_DIR) ? EVENT_IN : dir_down_ff;

  // ---------------------------------------------------------------
  // continuous comparators
  // ---------------------------------------------------------------
  // bottom detect
  wire at_bottom = (count_value_ff == 16'h0000);
  wire at_top = (count_value_ff == period_ff);
  // max detect; the up count wraps there on its own
  wire at_max = (count_value_ff == 16'hffff);
  wire lo_bottom = (count_value_ff[7:0] == 8'h00);
  wire lo_top = (count_value_ff[7:0] == period_ff[7:0]);
  wire hi_bottom = (count_value_ff[15:8] == 8'h00);
  wire hi_top = (count_value_ff[15:8] == period_ff[15:8]);

  wire bot_c = split_ff ? lo_bottom : at_bottom;
  wire top_c = split_ff ? lo_top : at_top;
  // update point at top or bottom per mode
  wire upd_cond = tick && (upd_bottom_ff ? bot_c : top_c);
  wire upd_fire = upd_cond && !update_lock_ff;

  // ---------------------------------------------------------------
  // compare channels
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1) begin : ch
      reg [15:0] cmp_ff;
      reg [15:0] cshd_ff;
      reg cvalid_ff;
      localparam [4:0] CH_OFS = g;
      wire wr_cmp = WR && (ADDR == (`TTA_ADDR_CMP_BASE + CH_OFS));
      wire wr_cshd = WR && (ADDR == (`TTA_ADDR_CMP_SHD + CH_OFS));
      always @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
          cmp_ff <= `TTA_RST_WORD;
          cshd_ff <= `TTA_RST_WORD;
          cvalid_ff <= 1'b0;
        end else begin
          // direct compare write bypasses the shadow
          if (wr_cmp) begin
            cmp_ff <= WDATA;
          end else if (upd_fire && cvalid_ff) begin
            cmp_ff <= cshd_ff;
          end
          if (wr_cshd) begin
            cshd_ff <= WDATA;
          end
          // write sets valid, winning over update clear
          if (wr_cshd) begin
            cvalid_ff <= 1'b1;
          end else if (upd_fire) begin
            cvalid_ff <= 1'b0;
          end
        end
      end
      assign cmp_all[g*16 +: 16] = cmp_ff;
      assign cshd_all[g*16 +: 16] = cshd_ff;
      assign compare_shadow_valid[g] = cvalid_ff;
      assign match16[g] = (count_value_ff == cmp_ff);
      assign match_lo[g] = (count_value_ff[7:0] == cmp_ff[7:0]);
      assign match_hi[g] = (count_value_ff[15:8] == cmp_ff[15:8]);
    end
  endgenerate

  // ---------------------------------------------------------------
  // count next-state
  // ---------------------------------------------------------------
  function [7:0] step8;
    input [7:0] val;
    input [7:0] per;
    input dn;
    input top;
    input bot;
    begin
      if (dn) begin
        step8 = bot ? per : val - 8'h01;
      end else begin
        step8 = top ? 8'h00 : val + 8'h01;
      end
    end
  endfunction

  reg [15:0] nxt_count_value;
  always @* begin
    nxt_count_value = count_value_ff;
    if (wr_count) begin
      nxt_count_value = WDATA;
    end else if (restart) begin
      nxt_count_value = down ? period_ff : 16'h0000;
    end else if (tick) begin
      if (split_ff) begin
        nxt_count_value[7:0] = step8(count_value_ff[7:0], period_ff[7:0], down, lo_top, lo_bottom);
        nxt_count_value[15:8] = step8(count_value_ff[15:8], period_ff[15:8], down, hi_top,
                                      hi_bottom);
      // reload period at bottom when down
      end else if (down) begin
        nxt_count_value = at_bottom ? period_ff : count_value_ff - 16'h0001;
      // wrap to zero after top when up
      end else begin
        nxt_count_value = (at_top || at_max) ? 16'h0000 : count_value_ff + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // tick-delayed effects
  // ---------------------------------------------------------------
  // the condition is the value reached on the previous tick, so the effect lands one tick later
  wire ovf_hit = split_ff ? (down ? lo_bottom : lo_top) : (down ? at_bottom : at_top);
  wire hovf_hit = split_ff && (down ? hi_bottom : hi_top);
  wire [NUM_CH-1:0] cmp_hit = split_ff ? match_lo : match16;
  wire [NUM_CH-1:0] hcmp_hit = split_ff ? match_hi : {NUM_CH{1'b0}};
  wire [7:0] flag_set = tick ? {hcmp_hit, cmp_hit, hovf_hit, ovf_hit} : 8'h00;

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  always @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      enable_ff <= 1'b0;
      prescale_select_ff <= 3'h0;
      split_ff <= 1'b0;
      upd_bottom_ff <= 1'b0;
      dir_down_ff <= 1'b0;
      update_lock_ff <= 1'b0;
      count_on_event_enable_ff <= 1'b0;
      ev_action_ff <= `TTA_EVACT_COUNT;
      count_value_ff <= `TTA_RST_WORD;
      period_ff <= `TTA_RST_PERIOD;
      period_shadow_ff <= `TTA_RST_PERIOD;
      period_shadow_valid_ff <= 1'b0;
      flags_ff <= 8'h00;
      presc_ff <= `TTA_RST_PRESC;
      ev_prev_ff <= 1'b0;
      OVF_EVENT <= 1'b0;
      HIGH_OVF_EVENT <= 1'b0;
      CMP_EVENT <= {NUM_CH{1'b0}};
      HIGH_CMP_EVENT <= {NUM_CH{1'b0}};
    end else begin
      // enable starts counting at the selected rate
      if (wr_main) begin
        enable_ff <= WDATA[`TTA_MAIN_ENABLE_BIT];
        prescale_select_ff <= WDATA[`TTA_MAIN_PSEL_LSB +: 3];
      end
      if (wr_mode) begin
        split_ff <= WDATA[`TTA_MODE_SPLIT_BIT];
        upd_bottom_ff <= WDATA[`TTA_MODE_UPDBOT_BIT];
      end
      if (wr_cmd) begin
        dir_down_ff <= WDATA[`TTA_CMD_DIR_BIT];
        update_lock_ff <= WDATA[`TTA_CMD_LOCK_BIT];
      end
      if (wr_evc) begin
        count_on_event_enable_ff <= WDATA[`TTA_EVC_COUNT_ON_EVENT_ENABLE_BIT];
        ev_action_ff <= WDATA[`TTA_EVC_ACT_LSB +: 2];
      end
      presc_ff <= enable_ff ? presc_ff + 10'h001 : `TTA_RST_PRESC;
      ev_prev_ff <= EVENT_IN;
      count_value_ff <= nxt_count_value;
      if (wr_period) begin
        period_ff <= WDATA;
      // valid period shadow copied at update
      end else if (upd_fire && period_shadow_valid_ff) begin
        period_ff <= period_shadow_ff;
      end
      if (wr_pshd) begin
        period_shadow_ff <= WDATA;
      end
      if (wr_pshd) begin
        period_shadow_valid_ff <= 1'b1;
      end else if (upd_fire) begin
        period_shadow_valid_ff <= 1'b0;
      end
      // match flag set on the tick, set beats write-one clear
      flags_ff <= (flags_ff & ~(wr_flags ? WDATA[7:0] : 8'h00)) | flag_set;
      // events one tick after the value was reached
      OVF_EVENT <= flag_set[`TTA_FLAG_OVF_BIT];
      HIGH_OVF_EVENT <= flag_set[`TTA_FLAG_HOVF_BIT];
      CMP_EVENT <= flag_set[`TTA_FLAG_CMP_LSB +: NUM_CH];
      HIGH_CMP_EVENT <= flag_set[`TTA_FLAG_HCMP_LSB +: NUM_CH];
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  reg [15:0] rd_mux;
  always @* begin
    rd_mux = 16'h0000;
    if (ADDR == `TTA_ADDR_MAIN_CTRL) begin
      rd_mux = {12'h000, prescale_select_ff, enable_ff};
    end else if (ADDR == `TTA_ADDR_MODE) begin
      rd_mux = {14'h0000, upd_bottom_ff, split_ff};
    end else if (ADDR == `TTA_ADDR_CMD_CTRL) begin
      rd_mux = {14'h0000, update_lock_ff, dir_down_ff};
    end else if (ADDR == `TTA_ADDR_SHADOW_FLAG) begin
      rd_mux = {12'h000, compare_shadow_valid, period_shadow_valid_ff};
    end else if (ADDR == `TTA_ADDR_EVENT_CTRL) begin
      rd_mux = {13'h0000, ev_action_ff, count_on_event_enable_ff};
    end else if (ADDR == `TTA_ADDR_FLAGS) begin
      rd_mux = {8'h00, flags_ff};
    end else if (ADDR == `TTA_ADDR_COUNT) begin
      rd_mux = count_value_ff;
    end else if (ADDR == `TTA_ADDR_PERIOD) begin
      rd_mux = period_ff;
    end else if (ADDR == `TTA_ADDR_PERIOD_SHD) begin
      rd_mux = period_shadow_ff;
    end else if (ADDR >= `TTA_ADDR_CMP_BASE && ADDR < `TTA_ADDR_CMP_BASE + 5'd3) begin
      rd_mux = cmp_all[(ADDR - `TTA_ADDR_CMP_BASE) * 16 +: 16];
    end else if (ADDR >= `TTA_ADDR_CMP_SHD && ADDR < `TTA_ADDR_CMP_SHD + 5'd3) begin
      rd_mux = cshd_all[(ADDR - `TTA_ADDR_CMP_SHD) * 16 +: 16];
    end
  end

  // read data only in the cycle after the strobe; zero otherwise
  always @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      RDATA <= 16'h0000;
    end else begin
      RDATA <= RD ? rd_mux : 16'h0000;
    end
  end

endmodule // tta_base_counter

// [logic/tta_defs.vh]
// register map, field positions and reset values of the buffered base timer/counter
`ifndef TTA_DEFS_VH
`define TTA_DEFS_VH

// register offsets, one 16-bit word each
`define TTA_ADDR_MAIN_CTRL   5'h00
`define TTA_ADDR_MODE        5'h01
`define TTA_ADDR_CMD_CTRL    5'h02
`define TTA_ADDR_SHADOW_FLAG 5'h03
`define TTA_ADDR_EVENT_CTRL  5'h04
`define TTA_ADDR_FLAGS       5'h05
`define TTA_ADDR_COUNT       5'h08
`define TTA_ADDR_PERIOD      5'h09
`define TTA_ADDR_PERIOD_SHD  5'h0a
`define TTA_ADDR_CMP_BASE    5'h0c
`define TTA_ADDR_CMP_SHD     5'h10

// main_control_reg fields
`define TTA_MAIN_ENABLE_BIT  0
`define TTA_MAIN_PSEL_LSB    1
// mode register fields
`define TTA_MODE_SPLIT_BIT   0
`define TTA_MODE_UPDBOT_BIT  1
// command_control_reg fields
`define TTA_CMD_DIR_BIT      0
`define TTA_CMD_LOCK_BIT     1
// event_control_reg fields
`define TTA_EVC_COUNT_ON_EVENT_ENABLE_BIT    0
`define TTA_EVC_ACT_LSB      1
`define TTA_EVACT_COUNT      2'h0
`define TTA_EVACT_DIR        2'h1
`define TTA_EVACT_RESTART    2'h2
// flag register fields
`define TTA_FLAG_OVF_BIT     0
`define TTA_FLAG_HOVF_BIT    1
`define TTA_FLAG_CMP_LSB     2
`define TTA_FLAG_HCMP_LSB    5

// reset values
`define TTA_RST_WORD         16'h0000
`define TTA_RST_PERIOD       16'hffff
`define TTA_RST_PRESC        10'h000

`endif

// [logic/tta_base_counter_chk_placeholder.v]
// intentionally empty design unit list: no further modules
`timescale 1ns/1ps

// [tb/tta_evt_src.sv]
// event system source: counted event pulses or a held level
`timescale 1ns/1ps
module tta_evt_src (
  // clock and reset
  input logic CLOCK,
  input logic RESET,
  // request
  input logic GO,
  input logic [3:0] NUM,
  input logic LEVEL,
  // event line
  output logic EV,
  output logic BUSY
);
  logic [4:0] cnt_ff;
  always @(posedge CLOCK or posedge RESET) begin
    if (RESET)
      cnt_ff <= 5'h00;
    else if (GO)
      cnt_ff <= {NUM, 1'b0};
    else if (cnt_ff != 5'h00)
      cnt_ff <= cnt_ff - 5'h01;
  end
  // idle line holds the direction level
  assign EV = (cnt_ff != 5'h00) ? cnt_ff[0] : LEVEL;
  assign BUSY = cnt_ff != 5'h00;
endmodule // tta_evt_src

// [tb/tta_base_counter_properties.sv]
// checker of the base counter register port and event outputs
`timescale 1ns/1ps
`include "tta_defs.vh"
module tta_base_counter_properties #(
  parameter NUM_CH = 3
) (
  // clock and reset
  input logic CLOCK,
  input logic RESET,
  // register port
  input logic [4:0] ADDR,
  input logic [15:0] WDATA,
  input logic WR,
  input logic RD,
  input logic [15:0] RDATA,
  // event system
  input logic EVENT_IN,
  input logic OVF_EVENT,
  input logic HIGH_OVF_EVENT,
  input logic [NUM_CH-1:0] CMP_EVENT,
  input logic [NUM_CH-1:0] HIGH_CMP_EVENT
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  // mirror of enable, so no tick can disturb a readback, and of split for the high-half check
  logic en_ff;
  logic split_ff;
  always @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      en_ff <= 1'b0;
      split_ff <= 1'b0;
    end else if (WR) begin
      if (ADDR == `TTA_ADDR_MAIN_CTRL)
        en_ff <= WDATA[`TTA_MAIN_ENABLE_BIT];
      if (ADDR == `TTA_ADDR_MODE)
        split_ff <= WDATA[`TTA_MODE_SPLIT_BIT];
    end
  end
  sequence wr_rd_idle(a);
    WR && ADDR == a && !en_ff ##1 RD && ADDR == a;
  endsequence
  sequence wr_then_flags(a);
    WR && ADDR == a && !en_ff ##1 RD && ADDR == `TTA_ADDR_SHADOW_FLAG;
  endsequence
  rd_idle_zero_a: assert property (!RD |=> RDATA == 16'h0000)
    else $error("read data not zero outside a read");
  unmapped_zero_a: assert property (RD && ADDR == 5'h1f |=> RDATA == 16'h0000)
    else $error("unmapped read not zero");
  count_write_a: assert property (wr_rd_idle(`TTA_ADDR_COUNT) |=> RDATA == $past(WDATA, 2))
    else $error("count write not read back");
  period_direct_a: assert property (wr_rd_idle(`TTA_ADDR_PERIOD) |=> RDATA == $past(WDATA, 2))
    else $error("period write not immediate");
  cmp_direct_a: assert property (wr_rd_idle(`TTA_ADDR_CMP_BASE) |=> RDATA == $past(WDATA, 2))
    else $error("compare write not immediate");
  shadow_valid_a: assert property (wr_then_flags(`TTA_ADDR_PERIOD_SHD) |=> RDATA[0] == 1'b1)
    else $error("period shadow valid not set");
  disabled_quiet_a: assert property (!en_ff |=> !OVF_EVENT && CMP_EVENT == '0)
    else $error("event while disabled");
  split_off_high_a: assert property (!split_ff |=> !HIGH_OVF_EVENT && HIGH_CMP_EVENT == '0)
    else $error("high half event outside split");
endmodule // tta_base_counter_properties

bind tta_base_counter tta_base_counter_properties #(.NUM_CH(NUM_CH)) u_tta_base_counter_properties (
  .CLOCK(CLOCK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .EVENT_IN(EVENT_IN), .OVF_EVENT(OVF_EVENT), .HIGH_OVF_EVENT(HIGH_OVF_EVENT),
  .CMP_EVENT(CMP_EVENT), .HIGH_CMP_EVENT(HIGH_CMP_EVENT));

// [tb/tta_base_counter_tb.sv]
// testbench of the buffered base timer/counter
`timescale 1ns/1ps
`include "tta_defs.vh"
`define CHK(g, e) \
  begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tta_base_counter_tb;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic go = 1'b0;
  logic lvl = 1'b0;
  logic [3:0] n_ev = 4'h0;
  logic [15:0] rdata;
  logic ev;
  logic busy;
  logic ovf;
  logic [2:0] cmp;
  logic hovf;
  logic [2:0] hcmp;
  logic [15:0] d;
  int hovf_seen = 0;
  int hcmp_seen = 0;
  int fails = 0;
  int check_count = 0;
  int ovf_seen = 0;
  int cmp_seen = 0;
  tta_base_counter u_tta_base_counter (.CLOCK(clock), .RESET(reset), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .EVENT_IN(ev), .OVF_EVENT(ovf),
    .HIGH_OVF_EVENT(hovf), .CMP_EVENT(cmp), .HIGH_CMP_EVENT(hcmp));
  tta_evt_src u_tta_evt_src (.CLOCK(clock), .RESET(reset), .GO(go), .NUM(n_ev),
    .LEVEL(lvl), .EV(ev), .BUSY(busy));
  initial begin
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (ovf === 1'b1) ovf_seen++;
    if (cmp[0] === 1'b1) cmp_seen++;
    if (hovf === 1'b1) hovf_seen++;
    if (hcmp[0] === 1'b1) hcmp_seen++;
  end
  // ----
  // bus and event tasks
  // ----
  task automatic report_and_stop;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge clock);
  endtask
  task automatic wr_rd(input logic [4:0] a, input logic [15:0] v, input logic [4:0] ra);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    rd_reg(ra, d);
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  endtask
  // waits for the source to finish, the last edge is counted by then
  task automatic events(input logic [3:0] k);
    int i;
    i = 0;
    n_ev <= k;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    do begin
      @(posedge clock);
      #1 i++;
    end while (busy === 1'b1 && i < 40);
    if (i >= 40) begin
      fails++;
      report_and_stop;
    end
    @(posedge clock);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset;
    rd_reg(`TTA_ADDR_PERIOD, d);
    `CHK(d, 16'hffff)
    rd_reg(`TTA_ADDR_COUNT, d);
    `CHK(d, 16'h0000)
    rd_reg(`TTA_ADDR_SHADOW_FLAG, d);
    `CHK(d, 16'h0000)
    rd_reg(5'h1f, d);
    `CHK(d, 16'h0000)
  endtask
  task automatic t_direct;
    wr_rd(`TTA_ADDR_COUNT, 16'h1234, `TTA_ADDR_COUNT);
    `CHK(d, 16'h1234)
    wr_rd(`TTA_ADDR_PERIOD, 16'h0004, `TTA_ADDR_PERIOD);
    `CHK(d, 16'h0004)
    wr_rd(`TTA_ADDR_CMP_BASE, 16'h0002, `TTA_ADDR_CMP_BASE);
    `CHK(d, 16'h0002)
    wr_rd(`TTA_ADDR_PERIOD_SHD, 16'h0004, `TTA_ADDR_SHADOW_FLAG);
    `CHK(d, 16'h0001)
    wr_rd(`TTA_ADDR_COUNT, 16'h0000, `TTA_ADDR_COUNT);
    `CHK(d, 16'h0000)
  endtask
  task automatic t_up_down;
    int o;
    int c;
    o = ovf_seen;
    c = cmp_seen;
    wr_reg(`TTA_ADDR_EVENT_CTRL, 16'h0001);
    wr_reg(`TTA_ADDR_MAIN_CTRL, 16'h0001);
    events(4'h6);
    rd_reg(`TTA_ADDR_COUNT, d);
    `CHK(d, 16'h0001)
    `CHK(ovf_seen - o, 1)
    `CHK(cmp_seen - c, 1)
    wr_reg(`TTA_ADDR_CMD_CTRL, 16'h0001);
    events(4'h3);
    rd_reg(`TTA_ADDR_COUNT, d);
    `CHK(d, 16'h0003)
    `CHK(ovf_seen - o, 2)
    `CHK(cmp_seen - c, 1)
  endtask
  task automatic t_buffer;
    wr_reg(`TTA_ADDR_CMD_CTRL, 16'h0000);
    wr_reg(`TTA_ADDR_COUNT, 16'h0003);
    wr_reg(`TTA_ADDR_PERIOD_SHD, 16'h0002);
    wr_reg(`TTA_ADDR_CMP_SHD, 16'h0007);
    rd_reg(`TTA_ADDR_SHADOW_FLAG, d);
    `CHK(d, 16'h0003)
    rd_reg(`TTA_ADDR_PERIOD, d);
    `CHK(d, 16'h0004)
    events(4'h2);
    rd_reg(`TTA_ADDR_PERIOD, d);
    `CHK(d, 16'h0002)
    rd_reg(`TTA_ADDR_CMP_BASE, d);
    `CHK(d, 16'h0007)
    rd_reg(`TTA_ADDR_SHADOW_FLAG, d);
    `CHK(d, 16'h0000)
    wr_reg(`TTA_ADDR_CMD_CTRL, 16'h0002);
    wr_reg(`TTA_ADDR_PERIOD_SHD, 16'h0009);
    events(4'h3);
    rd_reg(`TTA_ADDR_PERIOD, d);
    `CHK(d, 16'h0002)
    rd_reg(`TTA_ADDR_SHADOW_FLAG, d);
    `CHK(d, 16'h0001)
  endtask
  task automatic t_hold_and_events;
    wr_reg(`TTA_ADDR_MAIN_CTRL, 16'h0000);
    events(4'h2);
    rd_reg(`TTA_ADDR_COUNT, d);
    `CHK(d, 16'h0000)
    wr_reg(`TTA_ADDR_CMD_CTRL, 16'h0000);
    wr_reg(`TTA_ADDR_EVENT_CTRL, 16'h0003);
    wr_reg(`TTA_ADDR_COUNT, 16'h0005);
    wr_reg(`TTA_ADDR_MAIN_CTRL, 16'h0001);
    events(4'h2);
    rd_reg(`TTA_ADDR_COUNT, d);
    `CHK(d, 16'h0003)
    wr_reg(`TTA_ADDR_EVENT_CTRL, 16'h0004);
    wr_reg(`TTA_ADDR_COUNT, 16'h0009);
    wr_reg(`TTA_ADDR_MAIN_CTRL, 16'h000f);
    events(4'h1);
    rd_reg(`TTA_ADDR_COUNT, d);
    `CHK(d, 16'h0000)
  endtask
  task automatic t_split;
    int o;
    int c;
    o = ovf_seen;
    c = cmp_seen;
    wr_reg(`TTA_ADDR_MAIN_CTRL, 16'h0000);
    wr_reg(`TTA_ADDR_CMD_CTRL, 16'h0000);
    wr_reg(`TTA_ADDR_EVENT_CTRL, 16'h0001);
    wr_reg(`TTA_ADDR_MODE, 16'h0003);
    wr_reg(`TTA_ADDR_PERIOD, 16'h0201);
    wr_reg(`TTA_ADDR_PERIOD_SHD, 16'h0201);
    wr_reg(`TTA_ADDR_CMP_BASE, 16'h0101);
    wr_reg(`TTA_ADDR_CMP_BASE + 5'h01, 16'h3333);
    wr_reg(`TTA_ADDR_CMP_BASE + 5'h02, 16'h3333);
    wr_reg(`TTA_ADDR_COUNT, 16'h0000);
    wr_reg(`TTA_ADDR_FLAGS, 16'h00ff);
    wr_reg(`TTA_ADDR_MAIN_CTRL, 16'h0001);
    events(4'h3);
    rd_reg(`TTA_ADDR_COUNT, d);
    `CHK(d, 16'h0001)
    rd_reg(`TTA_ADDR_FLAGS, d);
    `CHK(d, 16'h0027)
    rd_reg(`TTA_ADDR_SHADOW_FLAG, d);
    `CHK(d, 16'h0000)
    `CHK(ovf_seen - o, 1)
    `CHK(cmp_seen - c, 1)
    `CHK(hovf_seen, 1)
    `CHK(hcmp_seen, 1)
  endtask
  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_reset;
    t_direct;
    t_up_down;
    t_buffer;
    t_hold_and_events;
    t_split;
    report_and_stop;
  end
endmodule // tta_base_counter_tb
